// ==== epi_pkg.sv ====
package epi_pkg;
  // Register word offsets, scaled by EPI_BYTE_ADDR_SCALE to byte addresses
  localparam logic [11:0] EPI_OFF_CFG_HIGH = 12'h0e0;
  localparam logic [11:0] EPI_OFF_CFG_LOW = 12'h0e1;
  localparam logic [11:0] EPI_OFF_PULLUP = 12'h0e2;
  localparam logic [11:0] EPI_OFF_IRQ_EN = 12'h0e3;
  localparam logic [11:0] EPI_OFF_IRQ_PEND = 12'h0e4;
  localparam logic [11:0] EPI_OFF_PIN_DATA = 12'h0f1;
  localparam logic [11:0] EPI_OFF_IRQ_MASK = 12'h100;
  localparam logic [11:0] EPI_BYTE_ADDR_SCALE = 12'h004;
  // Reset values
  localparam logic [7:0] EPI_RST_CFG = 8'h00;
  localparam logic [7:0] EPI_RST_PULLUP = 8'h00;
  localparam logic [7:0] EPI_RST_IRQ_EN = 8'h00;
  localparam logic [7:0] EPI_RST_PEND = 8'h00;
  localparam logic [7:0] EPI_RST_DATA = 8'h00;
  localparam logic [3:0] EPI_RST_MASK = 4'hf;
  // Pin configuration codes
  localparam logic [1:0] EPI_CFG_INPUT = 2'h0;
  localparam logic [1:0] EPI_CFG_OUTPUT = 2'h1;
  localparam logic [1:0] EPI_CFG_ALT_A = 2'h2;
  localparam logic [1:0] EPI_CFG_ALT_B = 2'h3;
  // Edge select codes
  localparam logic [1:0] EPI_EDGE_OFF = 2'h0;
  localparam logic [1:0] EPI_EDGE_FALL = 2'h1;
  localparam logic [1:0] EPI_EDGE_RISE = 2'h2;
  localparam logic [1:0] EPI_EDGE_BOTH = 2'h3;
  localparam int EPI_IRQ_LINES = 4;
  localparam int EPI_PINS = 8;

  typedef struct packed {
    logic timer_c_output;
    logic timer_b_pwm;
    logic uart_b_transmit;
    logic uart_b_receive_out;
    logic buzzer_output;
    logic [3:0] lcd_common;
  } epi_periph_out_s;

  typedef struct packed {
    logic uart_b_receive;
    logic [3:0] converter_select;
  } epi_periph_in_s;
endpackage

// ==== epi_port.sv ====
`timescale 1ns/100ps
module epi_port
  import epi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  input wire epi_periph_out_s periph_out,
  output epi_periph_in_s periph_in,
  output logic irq_req_n,
  output logic irq
);

  logic [7:0] cfg_high_q;
  logic [7:0] cfg_low_q;
  logic [7:0] pullup_q;
  logic [7:0] irq_en_q;
  logic [3:0] pend_q;
  logic [3:0] mask_q;
  logic [7:0] data_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [3:0] prev_q;
  logic [2:0] prev_valid_q;
  logic [15:0] cfg_all;
  logic [7:0] drive_d;
  logic [7:0] oe_d;
  logic [3:0] edge_hit;
  logic [31:0] rdata_d;
  logic acc;
  logic wr;
  logic addr_ok;

  assign cfg_all = {cfg_high_q, cfg_low_q};
  assign acc = psel && penable && clk_en;
  assign wr = acc && pwrite && pstrb[0];

  // Pin synchroniser, two stages
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end
    else if (clk_en)
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Configuration registers, reset to all inputs
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cfg_high_q <= EPI_RST_CFG;
    end
    else if (wr && paddr == EPI_OFF_CFG_HIGH * EPI_BYTE_ADDR_SCALE)
    begin
      cfg_high_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cfg_low_q <= EPI_RST_CFG;
    end
    else if (wr && paddr == EPI_OFF_CFG_LOW * EPI_BYTE_ADDR_SCALE)
    begin
      cfg_low_q <= pwdata[7:0];
    end
  end

  // Pull-up enables
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pullup_q <= EPI_RST_PULLUP;
    end
    else if (wr && paddr == EPI_OFF_PULLUP * EPI_BYTE_ADDR_SCALE)
    begin
      pullup_q <= pwdata[7:0];
    end
  end

  // Edge select fields
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_en_q <= EPI_RST_IRQ_EN;
    end
    else if (wr && paddr == EPI_OFF_IRQ_EN * EPI_BYTE_ADDR_SCALE)
    begin
      irq_en_q <= pwdata[7:0];
    end
  end

  // Mask, every line masked after reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mask_q <= EPI_RST_MASK;
    end
    else if (wr && paddr == EPI_OFF_IRQ_MASK * EPI_BYTE_ADDR_SCALE)
    begin
      mask_q <= pwdata[3:0];
    end
  end

  // Output latch; a read returns the pin levels instead
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      data_q <= EPI_RST_DATA;
    end
    else if (wr && paddr == EPI_OFF_PIN_DATA * EPI_BYTE_ADDR_SCALE)
    begin
      data_q <= pwdata[7:0];
    end
  end

  // Edge detection on the four interrupt lines
  always_comb
  begin
    edge_hit = 4'h0;
    for (int i = 0; i < EPI_IRQ_LINES; i++)
    begin
      unique case (irq_en_q[2*i +: 2])
        EPI_EDGE_FALL:
        begin
          edge_hit[i] = prev_q[i] && !sync2_q[i];
        end
        EPI_EDGE_RISE:
        begin
          edge_hit[i] = !prev_q[i] && sync2_q[i];
        end
        EPI_EDGE_BOTH:
        begin
          edge_hit[i] = prev_q[i] ^ sync2_q[i];
        end
        default:
        begin
          edge_hit[i] = 1'b0;
        end
      endcase
    end
    // Synchroniser still filling after reset: a high pin would look like an edge
    if (!prev_valid_q[2])
    begin
      edge_hit = 4'h0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prev_q <= 4'h0;
      prev_valid_q <= 3'h0;
    end
    else if (clk_en)
    begin
      prev_q <= sync2_q[3:0];
      prev_valid_q <= {prev_valid_q[1:0], 1'b1};
    end
  end

  // Pending bits: write 0 clears, write 1 keeps, a new edge wins
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pend_q <= EPI_RST_PEND[3:0];
    end
    else if (clk_en)
    begin
      if (wr && paddr == EPI_OFF_IRQ_PEND * EPI_BYTE_ADDR_SCALE)
      begin
        pend_q <= (pend_q & pwdata[3:0]) | edge_hit;
      end
      else
      begin
        pend_q <= pend_q | edge_hit;
      end
    end
  end

  // Request line ignores the mask
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_req_n <= 1'b1;
    end
    else if (clk_en)
    begin
      irq_req_n <= ~(|pend_q);
    end
  end

  // Masked level interrupt
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      irq <= |(pend_q & ~mask_q);
    end
  end

  // Pin output multiplexing
  always_comb
  begin
    drive_d = data_q;
    oe_d = 8'h00;
    for (int p = 0; p < EPI_PINS; p++)
    begin
      if (cfg_all[2*p +: 2] == EPI_CFG_OUTPUT)
      begin
        oe_d[p] = 1'b1;
      end
    end
    for (int c = 0; c < 3; c++)
    begin
      if (cfg_high_q[6-2*c +: 2] == EPI_CFG_ALT_B)
      begin
        drive_d[7-c] = periph_out.lcd_common[c];
        oe_d[7-c] = 1'b1;
      end
    end
    unique case (cfg_high_q[1:0])
      EPI_CFG_ALT_A:
      begin
        drive_d[4] = periph_out.timer_c_output;
        oe_d[4] = 1'b1;
      end
      EPI_CFG_ALT_B:
      begin
        drive_d[4] = periph_out.lcd_common[3];
        oe_d[4] = 1'b1;
      end
      default:
      begin
      end
    endcase
    if (cfg_low_q[7:6] == EPI_CFG_ALT_B)
    begin
      drive_d[3] = periph_out.uart_b_transmit;
      oe_d[3] = 1'b1;
    end
    if (cfg_low_q[5:4] == EPI_CFG_ALT_B)
    begin
      drive_d[2] = periph_out.uart_b_receive_out;
      oe_d[2] = 1'b1;
    end
    if (cfg_low_q[3:2] == EPI_CFG_ALT_B)
    begin
      drive_d[1] = periph_out.buzzer_output;
      oe_d[1] = 1'b1;
    end
    if (cfg_low_q[1:0] == EPI_CFG_ALT_B)
    begin
      drive_d[0] = periph_out.timer_b_pwm;
      oe_d[0] = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pin_pullup <= 8'h00;
    end
    else if (clk_en)
    begin
      pin_out <= drive_d;
      pin_oe <= oe_d;
      pin_pullup <= pullup_q & ~oe_d;
    end
  end

  // Peripheral side: receive level and converter routing
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      periph_in <= '0;
    end
    else if (clk_en)
    begin
      periph_in.uart_b_receive <= (cfg_low_q[5:4] == EPI_CFG_INPUT) && sync2_q[2];
      periph_in.converter_select[0] <= cfg_low_q[7:6] == EPI_CFG_ALT_A;
      periph_in.converter_select[1] <= cfg_low_q[5:4] == EPI_CFG_ALT_A;
      periph_in.converter_select[2] <= cfg_low_q[3:2] == EPI_CFG_ALT_A;
      periph_in.converter_select[3] <= cfg_low_q[1:0] == EPI_CFG_ALT_A;
    end
  end

  // APB read mux
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (paddr)
      EPI_OFF_CFG_HIGH * EPI_BYTE_ADDR_SCALE: rdata_d[7:0] = cfg_high_q;
      EPI_OFF_CFG_LOW * EPI_BYTE_ADDR_SCALE: rdata_d[7:0] = cfg_low_q;
      EPI_OFF_PULLUP * EPI_BYTE_ADDR_SCALE: rdata_d[7:0] = pullup_q;
      EPI_OFF_IRQ_EN * EPI_BYTE_ADDR_SCALE: rdata_d[7:0] = irq_en_q;
      EPI_OFF_IRQ_PEND * EPI_BYTE_ADDR_SCALE: rdata_d[3:0] = pend_q;
      EPI_OFF_PIN_DATA * EPI_BYTE_ADDR_SCALE: rdata_d[7:0] = sync2_q;
      EPI_OFF_IRQ_MASK * EPI_BYTE_ADDR_SCALE: rdata_d[3:0] = mask_q;
      default: addr_ok = 1'b0;
    endcase
  end

  // No wait state: pready in the first access cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite)
      begin
        prdata <= rdata_d;
      end
    end
  end
endmodule

// ==== epi_port_sva.sv ====
`timescale 1ns/100ps
module epi_port_sva
  import epi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire epi_periph_in_s periph_in,
  input wire logic irq_req_n,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_READY: assert property (psel && !penable |=> pready && penable)
    else $error("access without ready");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error outside ready");
  AST_RST_IN: assert property ($past(rst) |-> pin_oe == 8'h00)
    else $error("pin driven after reset");
  AST_PULLUP: assert property ((pin_pullup & pin_oe) == 8'h00)
    else $error("pull-up on driven pin");
  AST_UART_RX: assert property (periph_in.uart_b_receive |-> !pin_oe[2])
    else $error("receive on driven pin");
  AST_CONV0: assert property (periph_in.converter_select[0] |-> !pin_oe[3])
    else $error("converter pin driven");
  AST_CONV3: assert property (periph_in.converter_select[3] |-> !pin_oe[0])
    else $error("converter pin driven");
  AST_IRQ_LVL: assert property (irq |-> !irq_req_n)
    else $error("irq without request");
  AST_IRQ_HOLD: assert property (!irq_req_n && !(psel && pwrite) && !$past(psel && pwrite)
    |=> !irq_req_n)
    else $error("request dropped alone");
  AST_IRQ_REL: assert property ($rose(irq_req_n) |-> $past(psel && penable && pwrite, 2))
    else $error("request released without write");
  cover property (pslverr);
  cover property ($fell(irq_req_n));
  cover property (irq);
endmodule

// ==== epi_pin_model.sv ====
`timescale 1ns/100ps
module epi_pin_model
  import epi_pkg::*;
(
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_lvl,
  input wire logic [8:0] alt_lvl,
  output logic [7:0] pin_in,
  output epi_periph_out_s periph_out
);
  // Driven pins read back own drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  // Peripherals present the levels the bench sets
  assign periph_out = epi_periph_out_s'(alt_lvl);
endmodule

// ==== epi_port_tb.sv ====
`timescale 1ns/100ps
module epi_port_tb
  import epi_pkg::*;
;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq_req_n, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, ext_lvl;
  logic clk_en;
  logic [3:0] pstrb;
  logic [8:0] alt_lvl;
  epi_periph_out_s periph_out;
  epi_periph_in_s periph_in;
  int miscompares = 0;
  int total_checks = 0;
  epi_port epi_port_inst (.core_clk, .rst, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out,
    .pin_oe, .pin_pullup, .periph_out, .periph_in, .irq_req_n, .irq);
  epi_pin_model epi_pin_model_inst (.pin_out, .pin_oe, .ext_lvl, .alt_lvl, .pin_in,
    .periph_out);
  initial
  begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] off, input logic [31:0] wd);
    paddr <= off * EPI_BYTE_ADDR_SCALE;
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic t_reset();
    apb(0, EPI_OFF_CFG_HIGH, 0);
    chk(rd, {24'h0, EPI_RST_CFG});
    apb(0, EPI_OFF_CFG_LOW, 0);
    chk(rd, {24'h0, EPI_RST_CFG});
    apb(0, EPI_OFF_IRQ_PEND, 0);
    chk(rd, {24'h0, EPI_RST_PEND});
    apb(1, 12'h0ff, 32'h5a);
    chk({31'h0, er}, 32'h1);
    chk({24'h0, pin_oe}, 32'h0);
  endtask
  task automatic t_output();
    apb(1, EPI_OFF_CFG_HIGH, 32'h55);
    apb(1, EPI_OFF_CFG_LOW, 32'h55);
    apb(1, EPI_OFF_PIN_DATA, 32'ha5);
    apb(1, EPI_OFF_PULLUP, 32'hff);
    chk({pin_pullup, pin_oe, pin_out}, 32'h00ffa5);
    apb(0, EPI_OFF_PIN_DATA, 0);
    chk(rd, 32'ha5);
    apb(1, EPI_OFF_CFG_HIGH, 32'h00);
    apb(1, EPI_OFF_CFG_LOW, 32'haa);
    repeat (3) @(posedge core_clk);
    chk({pin_pullup, pin_oe, 4'h0, periph_in.converter_select}, 32'hff000f);
    apb(1, EPI_OFF_CFG_LOW, 32'h00);
  endtask
  task automatic t_alt();
    alt_lvl <= 9'h1b6;
    apb(1, EPI_OFF_CFG_HIGH, 32'hff);
    apb(1, EPI_OFF_CFG_LOW, 32'hff);
    @(posedge core_clk);
    chk({pin_oe, pin_out}, 32'hff67);
    apb(1, EPI_OFF_CFG_HIGH, 32'haa);
    @(posedge core_clk);
    chk({pin_oe, pin_out}, 32'h1fb7);
    chk({27'h0, periph_in}, 32'h0);
    apb(1, EPI_OFF_CFG_HIGH, 32'h00);
    apb(1, EPI_OFF_CFG_LOW, 32'h00);
    alt_lvl <= 9'h000;
  endtask
  task automatic t_freeze();
    pstrb <= 4'he;
    apb(1, EPI_OFF_CFG_HIGH, 32'h55);
    pstrb <= 4'hf;
    apb(0, EPI_OFF_CFG_HIGH, 0);
    chk(rd, 32'h0);
    clk_en <= 1'b0;
    ext_lvl <= 8'h08;
    repeat (6) @(posedge core_clk);
    chk({31'h0, irq_req_n}, 32'h1);
    clk_en <= 1'b1;
    repeat (6) @(posedge core_clk);
    apb(0, EPI_OFF_IRQ_PEND, 0);
    chk(rd, 32'h08);
  endtask
  task automatic t_rerun();
    apb(1, EPI_OFF_CFG_LOW, 32'h55);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk({24'h0, pin_oe}, 32'h0);
    apb(0, EPI_OFF_CFG_LOW, 0);
    chk(rd, {24'h0, EPI_RST_CFG});
    apb(0, EPI_OFF_IRQ_PEND, 0);
    chk(rd, {24'h0, EPI_RST_PEND});
  endtask
  task automatic t_edges();
    apb(1, EPI_OFF_IRQ_MASK, 0);
    apb(1, EPI_OFF_IRQ_EN, 32'he4);
    ext_lvl <= 8'h0f;
    repeat (6) @(posedge core_clk);
    apb(0, EPI_OFF_IRQ_PEND, 0);
    chk(rd, 32'h0c);
    chk({irq_req_n, irq, periph_in.uart_b_receive}, 32'h3);
    apb(1, EPI_OFF_IRQ_PEND, 32'hff);
    apb(0, EPI_OFF_IRQ_PEND, 0);
    chk(rd, 32'h0c);
    apb(1, EPI_OFF_IRQ_PEND, 0);
    repeat (2) @(posedge core_clk);
    chk({irq_req_n, irq}, 32'h2);
    ext_lvl <= 8'h00;
    repeat (6) @(posedge core_clk);
    apb(1, EPI_OFF_IRQ_MASK, 32'hf);
    repeat (2) @(posedge core_clk);
    chk({irq_req_n, irq}, 32'h0);
    apb(0, EPI_OFF_IRQ_PEND, 0);
    chk(rd, 32'h0a);
    apb(1, EPI_OFF_IRQ_PEND, 0);
    repeat (6) @(posedge core_clk);
    apb(0, EPI_OFF_IRQ_PEND, 0);
    chk(rd, 32'h0);
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ext_lvl} = '0;
    clk_en = 1'b1;
    pstrb = 4'hf;
    alt_lvl = 9'h000;
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_output();
    t_alt();
    t_edges();
    t_freeze();
    t_rerun();
    test_done();
  end
  initial
  begin
    #40000;
    miscompares++;
    test_done();
  end
endmodule
bind epi_port epi_port_sva epi_port_sva_inst (.core_clk, .rst, .psel, .penable, .pwrite,
  .pready, .pslverr, .pin_oe, .pin_pullup, .periph_in, .irq_req_n, .irq);
